// File: hdl/dsch_defines.svh
// register indices, bit positions, reset values and cycle counts of the debug status block
`ifndef DSCH_DEFINES_SVH
`define DSCH_DEFINES_SVH

// ------------------------------------------------------------
// register indices on the debug register port
// ------------------------------------------------------------
`define DSCH_IDX_STATUS 3'h1
`define DSCH_IDX_CCR 3'h6

// ------------------------------------------------------------
// status byte bit positions
// ------------------------------------------------------------
`define DSCH_BIT_EN 3'h7
`define DSCH_BIT_ACT 3'h6
`define DSCH_BIT_TAG 3'h5
`define DSCH_BIT_SDV 3'h4
`define DSCH_BIT_STEP 3'h3
`define DSCH_BIT_SW 3'h2
`define DSCH_BIT_UNSECURE_FLAG 3'h1

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define DSCH_CCR_RST 8'hD8
`define DSCH_STATUS_RST 8'h00
`define DSCH_RD_ZERO 8'h00
`define DSCH_CNT_W 8
`define DSCH_TAG_DELAY 8'h10
`define DSCH_CLOCK_SWITCH_DELAY 8'h96

`endif

// File: hdl/dsch_pkg.sv
// types shared by the debug status and condition-code holding block
package dsch_pkg;

  // who issued a register access
  typedef enum logic [1:0] {
    SRC_HW = 2'b00,
    SRC_FW = 2'b01,
    SRC_SEC = 2'b11
  } dsch_src_t;

  // debug clock selection
  typedef enum logic [1:0] {
    CLK_BUS = 2'b00,
    CLK_ALT = 2'b01,
    CLK_PLL = 2'b11
  } dsch_clk_t;

  // tagging sequence, gray along idle -> arm -> on
  typedef enum logic [1:0] {
    TAG_IDLE = 2'b00,
    TAG_ARM = 2'b01,
    TAG_ON = 2'b11
  } dsch_tag_t;

  // one register access from the command decoder
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] index;
    logic [7:0] data;
    dsch_src_t src;
  } dsch_req_t;

  // delay timer state
  typedef struct packed {
    logic [7:0] cnt;
    logic busy;
    logic done;
  } dsch_tmr_t;

  // whole state of the status block
  typedef struct packed {
    logic en;
    logic act;
    logic tag;
    logic data_phase_complete;
    logic step;
    logic sw;
    logic unsecure_flag;
    logic [7:0] ccr;
    dsch_tag_t tagSt;
    logic tagOn;
    logic serOn;
    dsch_clk_t ackSel;
    dsch_clk_t cmdSel;
    dsch_clk_t oldSel;
    logic settled;
    logic secMap;
    logic [7:0] rdData;
  } dsch_state_t;

endpackage

// File: hdl/dsch_timer.sv
// delay timer counting enabled ticks and pulsing when the count runs out
`timescale 1ns/10ps
`include "dsch_defines.svh"
module dsch_timer
  import dsch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [`DSCH_CNT_W-1:0] load,
  input wire logic tick,
  output logic done
);

  dsch_tmr_t st;
  dsch_tmr_t next_st;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // a start while busy reloads, so a second change restarts the wait
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.cnt = load;
      next_st.busy = 1'b1;
    end else if (st.busy && tick) begin
      if (st.cnt <= 8'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      next_st.cnt = st.cnt - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

endmodule

// File: hdl/dsch_status.sv
// debug status flags, clock switch and condition-code holding register
`timescale 1ns/10ps
`include "dsch_defines.svh"
// Operation
// - tag-go sets tagging flag; entry clears it
// - tagging takes over sixteen cycles after write
// - no serial commands served while tagging
// - data phase done sets shift-valid flag
// - next command or exit clears shift-valid
// - single-step flag set, held across repeats
// - other command clears single-step flag
// - clock switch writable by hardware command only
// - new clock settled after 150 old cycles
// - next command times on new clock
// - clock from pll select and switch
// - alternate clock fully synchronous, no limit
// - acknowledge of switching write at new rate
// - unsecure written only by secure firmware
// - secure table mapped in special mode while unsecure is zero
// - passing erase check sets unsecure, unmaps
// - unsecure reads zero secured, resets zero
// - entry copies cpu condition code
// - holding register resets to D8
// - holding register writable, restored to cpu
// - holding register usable as scratch byte
// - enable gates entry, hardware commands allowed
// - active set on entry, cleared by exit
// - registers reached only via debug commands
module dsch_status
  import dsch_pkg::*;
#(
  parameter logic [`DSCH_CNT_W-1:0] TAG_DELAY = `DSCH_TAG_DELAY,
  parameter logic [`DSCH_CNT_W-1:0] CLOCK_SWITCH_DELAY = `DSCH_CLOCK_SWITCH_DELAY
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire dsch_req_t regReq,
  input wire logic cmdRecognized,
  input wire logic cmdIsStep,
  input wire logic tagGoExec,
  input wire logic enterBackground,
  input wire logic exitBackground,
  input wire logic dataShifted,
  input wire logic specialMode,
  input wire logic pllSelect,
  input wire logic altClkTick,
  input wire logic [7:0] cpuCcr,
  output logic [7:0] regRdData,
  output logic [7:0] ccrRestore,
  output logic debugEnable,
  output logic debugActive,
  output logic taggingActive,
  output logic serialEnable,
  output logic secureTableMapped,
  output dsch_clk_t ackClkSel,
  output dsch_clk_t cmdClkSel,
  output logic clkSettled
);

  dsch_state_t st;
  dsch_state_t next_st;
  logic entry;
  logic live;
  logic cmdOk;
  logic wrOk;
  logic wrSts;
  logic stdSrc;
  logic tagStart;
  logic tagDone;
  logic swStart;
  logic swDone;
  logic swTick;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // debug clock choice
  function automatic dsch_clk_t clkPick(input logic pll, input logic sw);
    dsch_clk_t c;
    c = CLK_BUS;
    if (pll && !sw) begin
      c = CLK_ALT;
    end else if (pll && sw) begin
      c = CLK_PLL;
    end
    return c;
  endfunction

  // status byte, bit zero tied low
  function automatic logic [7:0] statusByte(input dsch_state_t s);
    logic [7:0] b;
    b = `DSCH_STATUS_RST;
    b[`DSCH_BIT_EN] = s.en;
    b[`DSCH_BIT_ACT] = s.act;
    b[`DSCH_BIT_TAG] = s.tag;
    b[`DSCH_BIT_SDV] = s.data_phase_complete;
    b[`DSCH_BIT_STEP] = s.step;
    b[`DSCH_BIT_SW] = s.sw;
    b[`DSCH_BIT_UNSECURE_FLAG] = s.unsecure_flag;
    return b;
  endfunction

  // ------------------------------------------------------------
  // delay timers
  // ------------------------------------------------------------
  // one less than the delay, the flag flop adds the last edge
  dsch_timer u_tagTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(tagStart),
    .load(TAG_DELAY - 8'h01),
    .tick(1'b1),
    .done(tagDone)
  );

  // alternate ticks arrive as enables on this clock, any rate works
  assign swTick = (st.oldSel == CLK_ALT) ? altClkTick : 1'b1;

  // counts cycles of the clock that was in use for the write
  dsch_timer u_swTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(swStart),
    .load(CLOCK_SWITCH_DELAY),
    .tick(swTick),
    .done(swDone)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // register writes first, hardware events after, so an event beats a write in the same cycle, except a clock switch write that beats swDone
  always_comb begin
    next_st = st;
    tagStart = 1'b0;
    swStart = 1'b0;
    // entry only when enabled and not yet active
    entry = enterBackground && st.en && !st.act;
    // serial side is deaf while tagging runs
    live = st.tagSt != TAG_ON;
    cmdOk = cmdRecognized && live;
    // registers only through the command decoder port
    wrOk = regReq.valid && regReq.write && live;
    wrSts = wrOk && (regReq.index == `DSCH_IDX_STATUS);
    stdSrc = (regReq.src == SRC_HW) || (regReq.src == SRC_FW);

    // general status bits from hardware or standard firmware writes
    if (wrSts && stdSrc) begin
      next_st.en = regReq.data[`DSCH_BIT_EN];
      next_st.data_phase_complete = regReq.data[`DSCH_BIT_SDV];
      next_st.step = regReq.data[`DSCH_BIT_STEP];
    end

    // clock switch from hardware commands only
    if (wrSts && (regReq.src == SRC_HW) && (regReq.data[`DSCH_BIT_SW] != st.sw)) begin
      next_st.sw = regReq.data[`DSCH_BIT_SW];
      next_st.oldSel = st.ackSel;
      next_st.settled = 1'b0;
      swStart = 1'b1;
    end
    // settled once the old clock has run its count
    if (swDone && !swStart) begin
      next_st.settled = 1'b1;
    end
    // acknowledge follows the new selection at once
    next_st.ackSel = clkPick(pllSelect, next_st.sw);
    // serial timing switches at the next command start
    if (cmdOk) begin
      next_st.cmdSel = next_st.ackSel;
    end

    // unsecure only from secure firmware in special mode
    if (wrSts && (regReq.src == SRC_SEC) && specialMode) begin
      // firmware sets it when the erase check passes
      next_st.unsecure_flag = regReq.data[`DSCH_BIT_UNSECURE_FLAG];
    end
    next_st.secMap = specialMode && !next_st.unsecure_flag;

    // single-step flag follows each recognized command served outside tagging
    if (cmdOk) begin
      next_st.step = cmdIsStep;
    end

    // cleared by next command or by exit
    if (cmdOk || exitBackground) begin
      next_st.data_phase_complete = 1'b0;
    end
    // data phase done, wins over a clear
    if (dataShifted && live) begin
      next_st.data_phase_complete = 1'b1;
    end

    // active cleared by the exit store, set on entry
    if (exitBackground) begin
      next_st.act = 1'b0;
    end
    if (entry) begin
      next_st.act = 1'b1;
    end

    // written value restored to cpu, also scratch
    if (wrOk && (regReq.index == `DSCH_IDX_CCR)) begin
      next_st.ccr = regReq.data;
    end
    if (entry) begin
      next_st.ccr = cpuCcr;
    end

    // tag-go or a write of the flag starts the arm sequence
    unique case (st.tagSt)
      TAG_IDLE: begin
        if ((tagGoExec && live) || (wrSts && stdSrc && regReq.data[`DSCH_BIT_TAG])) begin
          next_st.tag = 1'b1;
          next_st.tagSt = TAG_ARM;
          tagStart = 1'b1;
        end
      end
      TAG_ARM: begin
        // hand over to tagging after the delay
        if (tagDone) begin
          next_st.tagSt = TAG_ON;
        end
      end
      TAG_ON: begin
        next_st.tagSt = TAG_ON;
      end
      default: begin
        next_st.tagSt = TAG_IDLE;
      end
    endcase
    if (entry) begin
      next_st.tag = 1'b0;
      next_st.tagSt = TAG_IDLE;
      tagStart = 1'b0;
    end
    next_st.tagOn = next_st.tagSt == TAG_ON;
    next_st.serOn = next_st.tagSt != TAG_ON;

    // read port, unmapped indices read zero
    if (regReq.valid && !regReq.write && live) begin
      unique case (regReq.index)
        `DSCH_IDX_STATUS: next_st.rdData = statusByte(st);
        `DSCH_IDX_CCR: next_st.rdData = st.ccr;
        default: next_st.rdData = `DSCH_RD_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // unsecure resets to zero, holding register to D8
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.ccr <= `DSCH_CCR_RST;
      st.serOn <= 1'b1;
      st.settled <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from the state register
  // ------------------------------------------------------------
  assign regRdData = st.rdData;
  assign ccrRestore = st.ccr;
  assign debugEnable = st.en;
  assign debugActive = st.act;
  assign taggingActive = st.tagOn;
  assign serialEnable = st.serOn;
  assign secureTableMapped = st.secMap;
  assign ackClkSel = st.ackSel;
  assign cmdClkSel = st.cmdSel;
  assign clkSettled = st.settled;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  property p_tag_delay;
    $rose(taggingActive) |-> $past(tagStart, 17);
  endproperty
  a_tag_delay: assert property (p_tag_delay) else $error("tagging not 16 cycles after arm");

  property p_tag_entry;
    entry |=> !st.tag && !taggingActive && serialEnable;
  endproperty
  a_tag_entry: assert property (p_tag_entry) else $error("entry left tagging on");

  property p_deaf;
    taggingActive && cmdRecognized && !exitBackground |=> $stable(st.data_phase_complete) && $stable(st.step);
  endproperty
  a_deaf: assert property (p_deaf) else $error("command served while tagging");

  property p_sdv_set;
    dataShifted && live |=> st.data_phase_complete;
  endproperty
  a_sdv_set: assert property (p_sdv_set) else $error("shift-valid not set");

  property p_sdv_clr;
    (cmdOk || exitBackground) && !dataShifted |=> !st.data_phase_complete;
  endproperty
  a_sdv_clr: assert property (p_sdv_clr) else $error("shift-valid not cleared");

  property p_step;
    cmdOk |=> st.step == $past(cmdIsStep);
  endproperty
  a_step: assert property (p_step) else $error("single-step flag wrong");

  property p_sw_src;
    wrSts && regReq.src != SRC_HW |=> $stable(st.sw);
  endproperty
  a_sw_src: assert property (p_sw_src) else $error("clock switch moved by firmware");

  property p_settle;
    swStart ##1 (!swStart && !altClkTick)[*8] |-> !clkSettled;
  endproperty
  a_settle: assert property (p_settle) else $error("clock settled too early");

  property p_bus_sel;
    !pllSelect |=> ackClkSel == CLK_BUS;
  endproperty
  a_bus_sel: assert property (p_bus_sel) else $error("debug clock not bus clock");

  property p_unsecure_flag;
    wrSts && !(regReq.src == SRC_SEC && specialMode) |=> $stable(st.unsecure_flag);
  endproperty
  a_unsecure_flag: assert property (p_unsecure_flag) else $error("unsecure written by wrong source");

  property p_ccr_cap;
    entry |=> ccrRestore == $past(cpuCcr);
  endproperty
  a_ccr_cap: assert property (p_ccr_cap) else $error("condition code not captured");

  property p_gate;
    enterBackground && !debugEnable && !debugActive |=> !debugActive;
  endproperty
  a_gate: assert property (p_gate) else $error("entry while disabled");

  c_tag_on: cover property (tagStart ##[1:40] taggingActive);
  c_sw_done: cover property (swStart ##[1:400] $rose(clkSettled));
  c_unsecure_flag: cover property ($rose(st.unsecure_flag) && !secureTableMapped);
  c_step_run: cover property (cmdOk && cmdIsStep ##[1:20] cmdOk && cmdIsStep);

endmodule

// File: test/dsch_host.sv
// host side model of the serial debug link: register and command traffic
`timescale 1ns/10ps
module dsch_host
  import dsch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic serialEnable,
  input wire logic clkSettled,
  input wire logic [7:0] regRdData,
  output dsch_req_t regReq,
  output logic cmdRecognized,
  output logic cmdIsStep
);
  // quiet link until the first command
  initial begin
    regReq = '0;
    cmdRecognized = 1'b0;
    cmdIsStep = 1'b0;
  end

  // hold off until the new debug clock is settled
  task automatic wait_settled();
    int n;
    n = 0;
    while (clkSettled !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  // registers only by command, served only while link is on
  task automatic access(input dsch_src_t s, input logic w, input logic [2:0] i,
      input logic [7:0] d, output logic [7:0] rd, output logic ok);
    @(posedge ref_clk);
    regReq <= '{valid: 1'b1, write: w, index: i, data: d, src: s};
    @(posedge ref_clk);
    ok = serialEnable;
    // released lines flip so a stale value never passes for a fresh one
    regReq <= '{valid: 1'b0, write: ~w, index: ~i, data: ~d, src: s};
    #1;
    rd = regRdData;
  endtask

  // a new command starts only on a settled clock
  task automatic command(input logic step);
    wait_settled();
    @(posedge ref_clk);
    cmdRecognized <= 1'b1;
    cmdIsStep <= step;
    @(posedge ref_clk);
    cmdRecognized <= 1'b0;
    cmdIsStep <= ~step;
    #1;
  endtask
endmodule

// File: test/debug_status_and_ccr_holding_tb.sv
// self-checking bench of the debug status and condition-code holding block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); \
  end \
end
module debug_status_and_ccr_holding_tb
  import dsch_pkg::*;
;
  // ------------------------------------------------------------
  // signals and stimulus table
  // ------------------------------------------------------------
  typedef struct packed {
    dsch_src_t src;
    logic [2:0] idx;
    logic [7:0] wd;
    logic pll;
    logic sp;
    logic [7:0] exp;
    dsch_clk_t sel;
  } dsch_row_t;
  localparam logic [7:0] TAGD = 8'h10;
  localparam logic [7:0] SWD = 8'h96;
  localparam logic [3:0] TAG_GO_COMMAND = 4'h8;
  localparam logic [3:0] ENTER = 4'h4;
  localparam logic [3:0] EXIT = 4'h2;
  localparam logic [3:0] SHIFT = 4'h1;
  // rows walk the write permissions and the clock selection table
  localparam dsch_row_t ROWS [12] = '{
    '{SRC_HW, 3'h1, 8'h81, 1'b0, 1'b1, 8'h80, CLK_BUS},
    '{SRC_FW, 3'h1, 8'hC4, 1'b0, 1'b1, 8'h80, CLK_BUS},
    '{SRC_HW, 3'h1, 8'h84, 1'b0, 1'b1, 8'h84, CLK_BUS},
    '{SRC_HW, 3'h1, 8'h80, 1'b1, 1'b1, 8'h80, CLK_ALT},
    '{SRC_HW, 3'h1, 8'h84, 1'b1, 1'b1, 8'h84, CLK_PLL},
    '{SRC_FW, 3'h1, 8'h80, 1'b1, 1'b1, 8'h84, CLK_PLL},
    '{SRC_FW, 3'h1, 8'h86, 1'b1, 1'b1, 8'h84, CLK_PLL},
    '{SRC_SEC, 3'h1, 8'h86, 1'b1, 1'b0, 8'h84, CLK_PLL},
    '{SRC_SEC, 3'h1, 8'h86, 1'b1, 1'b1, 8'h86, CLK_PLL},
    '{SRC_HW, 3'h6, 8'h5A, 1'b1, 1'b1, 8'h5A, CLK_PLL},
    '{SRC_FW, 3'h6, 8'hA5, 1'b1, 1'b1, 8'hA5, CLK_PLL},
    '{SRC_HW, 3'h2, 8'h33, 1'b1, 1'b1, 8'h00, CLK_PLL}
  };
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic specialMode = 1'b1;
  logic [7:0] cpuCcr = 8'h3C;
  logic pllSelect = 1'b0;
  logic altClkTick = 1'b0;
  logic [3:0] evt = 4'h0;
  dsch_req_t regReq;
  logic cmdRecognized, cmdIsStep;
  logic [7:0] regRdData, ccrRestore, rdv;
  logic debugEnable, debugActive, taggingActive, serialEnable;
  logic secureTableMapped, clkSettled, ok;
  dsch_clk_t ackClkSel, cmdClkSel;
  int cyc = 0;
  int t0 = 0;
  int bad_count = 0;
  int checked = 0;

  // bus clock, and an alternate clock enable every fourth cycle
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    altClkTick <= (cyc % 4 == 3);
  end

  dsch_status uut (
    .ref_clk(ref_clk), .reset(reset), .regReq(regReq),
    .cmdRecognized(cmdRecognized), .cmdIsStep(cmdIsStep),
    .tagGoExec(evt[3]), .enterBackground(evt[2]), .exitBackground(evt[1]),
    .dataShifted(evt[0]), .specialMode(specialMode), .pllSelect(pllSelect),
    .altClkTick(altClkTick), .cpuCcr(cpuCcr), .regRdData(regRdData),
    .ccrRestore(ccrRestore), .debugEnable(debugEnable), .debugActive(debugActive),
    .taggingActive(taggingActive), .serialEnable(serialEnable),
    .secureTableMapped(secureTableMapped), .ackClkSel(ackClkSel),
    .cmdClkSel(cmdClkSel), .clkSettled(clkSettled)
  );
  dsch_host host (
    .ref_clk(ref_clk), .serialEnable(serialEnable), .clkSettled(clkSettled),
    .regRdData(regRdData), .regReq(regReq), .cmdRecognized(cmdRecognized),
    .cmdIsStep(cmdIsStep)
  );

  // ------------------------------------------------------------
  // helper tasks
  // ------------------------------------------------------------
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task wr(input dsch_src_t s, input logic [2:0] i, input logic [7:0] d);
    host.access(s, 1'b1, i, d, rdv, ok);
  endtask
  task rdb(input logic [2:0] i);
    host.access(SRC_HW, 1'b0, i, 8'h00, rdv, ok);
  endtask
  // one-cycle event; t0 marks the cycle after the taking edge
  task pulse(input logic [3:0] m);
    @(posedge ref_clk);
    evt <= m;
    @(posedge ref_clk);
    evt <= 4'h0;
    #1;
    t0 = cyc;
  endtask
  // bounded wait for settled (sel 1) or tagging (sel 0)
  task automatic wait_hi(input logic sel);
    int n;
    n = 0;
    while ((sel ? clkSettled : taggingActive) !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  task check_reset();
    rdb(3'h1);
    `CHK("status", 8'h00, rdv)
    rdb(3'h6);
    `CHK("holding", 8'hD8, rdv)
    `CHK("serial on", 1'b1, serialEnable)
    `CHK("settled", 1'b1, clkSettled)
    `CHK("ack clock", CLK_BUS, ackClkSel)
    `CHK("cmd clock", CLK_BUS, cmdClkSel)
    `CHK("mapped", 1'b1, secureTableMapped)
    $display("test reset done");
  endtask

  // watchdog well beyond the longest expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    check_reset();
    foreach (ROWS[k]) begin
      @(posedge ref_clk);
      pllSelect <= ROWS[k].pll;
      specialMode <= ROWS[k].sp;
      wr(ROWS[k].src, ROWS[k].idx, ROWS[k].wd);
      host.wait_settled();
      rdb(ROWS[k].idx);
      `CHK("row read", ROWS[k].exp, rdv)
      if (ROWS[k].idx == 3'h1) begin
        `CHK("row clock", ROWS[k].sel, ackClkSel)
        `CHK("row map", ROWS[k].sp & ~ROWS[k].exp[1], secureTableMapped)
      end
      if (ROWS[k].idx == 3'h6) `CHK("restore", ROWS[k].wd, ccrRestore)
    end
    $display("test table done");
    // switch from pll clock to alternate clock
    host.command(1'b0);
    `CHK("cmd clock", CLK_PLL, cmdClkSel)
    wr(SRC_HW, 3'h1, 8'h82);
    t0 = cyc;
    `CHK("ack clock", CLK_ALT, ackClkSel)
    `CHK("unsettled", 1'b0, clkSettled)
    wait_hi(1'b1);
    // settled flag trails the last counted edge by one, so never early
    `CHK("settle cycles", int'(SWD) + 1, cyc - t0)
    `CHK("cmd clock", CLK_PLL, cmdClkSel)
    host.command(1'b0);
    `CHK("cmd clock", CLK_ALT, cmdClkSel)
    $display("test clock switch done");
    // step and shift flags
    host.command(1'b1);
    rdb(3'h1);
    `CHK("step", 8'h8A, rdv)
    host.command(1'b1);
    pulse(SHIFT);
    rdb(3'h1);
    `CHK("step shift", 8'h9A, rdv)
    host.command(1'b0);
    rdb(3'h1);
    `CHK("cleared", 8'h82, rdv)
    $display("test step done");
    // tagging, refused traffic, then entry and exit
    pulse(TAG_GO_COMMAND);
    rdb(3'h1);
    `CHK("tag bit", 8'hA2, rdv)
    wait_hi(1'b0);
    `CHK("tag cycles", int'(TAGD), cyc - t0)
    `CHK("serial off", 1'b0, serialEnable)
    rdb(3'h6);
    `CHK("refused read", 8'hA2, rdv)
    host.command(1'b1);
    pulse(ENTER);
    `CHK("tag off", 1'b0, taggingActive)
    `CHK("active", 1'b1, debugActive)
    `CHK("captured", 8'h3C, ccrRestore)
    rdb(3'h1);
    `CHK("entered", 8'hC2, rdv)
    pulse(SHIFT);
    wr(SRC_HW, 3'h6, 8'h77);
    `CHK("restore", 8'h77, ccrRestore)
    rdb(3'h1);
    `CHK("shift", 8'hD2, rdv)
    pulse(EXIT);
    rdb(3'h1);
    `CHK("exited", 8'h82, rdv)
    wr(SRC_HW, 3'h1, 8'h02);
    @(posedge ref_clk);
    cpuCcr <= 8'hC3;
    pulse(ENTER);
    `CHK("gated", 1'b0, debugActive)
    `CHK("enable bit", 1'b0, debugEnable)
    `CHK("no capture", 8'h77, ccrRestore)
    $display("test tagging done");
    // second reset must secure the part again
    @(posedge ref_clk);
    pllSelect <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    check_reset();
    tally_and_finish();
  end
endmodule
